// ==== rtl/fifo_irq_status.sv ====

`include "fifo_irq_map.svh"

`default_nettype none

module fifo_irq_status
	import fifo_irq_pkg::*;
(
	input  wire logic      clk,
	input  wire logic      resetn,
	// register port
	input  wire logic      reg_wr,
	input  wire logic      reg_rd,
	input  wire logic [2:0] reg_addr,
	input  wire word_t     reg_wdata,
	output var  word_t     reg_rdata_q,
	output logic           reg_rvalid_q,
	// per-fifo condition flags and their enables from the fifo registers
	input  wire flag_arr_t rx_flags,
	input  wire flag_arr_t rx_enables,
	input  wire flag_arr_t tx_flags,
	input  wire flag_arr_t tx_enables,
	input  wire word_t     rx_overflow_flags,
	input  wire word_t     tx_attempt_flags,
	input  wire word_t     fifo_transmit_select,
	// protocol engine side of the send requests
	input  wire word_t     tx_fifo_done,
	output var  word_t     send_request_bits,
	output logic [6:0]     interrupt_code_vector
);

	// true when any bit of a vector is set
	function automatic logic any_set(input word_t v);
		return |v;
	endfunction : any_set

	// index of the highest set bit, zero when none is set
	function automatic logic [4:0] top_index(input word_t v);
		logic [4:0] idx;
		idx = 5'h00;
		for (int i = 0; i < 32; i++) begin
			if (v[i]) begin
				idx = 5'(i);
			end
		end
		return idx;
	endfunction : top_index

	word_t     rx_pend_w;
	word_t     tx_pend_w;
	word_t     rx_fifo_pending_bits_q;
	word_t     rx_overflow_pending_bits_q;
	word_t     tx_fifo_pending_bits_q;
	word_t     tx_attempt_pending_bits_q;
	word_t     send_req_q;
	word_t     send_req_d;
	word_t     tx_capable;
	word_t     set_req;
	word_t     fifo_any;
	word_t     rdata_d;
	logic      wr_req;
	logic      rd_hit;
	code_cls_e code_cls;
	logic [6:0] code_d;
	logic [6:0] code_q;

	// receive side reduction, transmit queue position forced low
	fifo_flag_reduce u_rx_reduce (
		.flags     (rx_flags),
		.enables   (rx_enables),
		.keep_mask (`RX_FIFO_MASK),
		.pending   (rx_pend_w)
	);

	// transmit side reduction keeps all 32 positions, queue at bit0
	fifo_flag_reduce u_tx_reduce (
		.flags     (tx_flags),
		.enables   (tx_enables),
		.keep_mask (32'hFFFFFFFF),
		.pending   (tx_pend_w)
	);

	// status vectors track their sources every cycle; software has no write
	// path into them, so a stray write cannot lose a pending indication
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rx_fifo_pending_bits_q     <= `STATUS_RST;
			rx_overflow_pending_bits_q <= `STATUS_RST;
			tx_fifo_pending_bits_q     <= `STATUS_RST;
			tx_attempt_pending_bits_q  <= `STATUS_RST;
		end else begin
			rx_fifo_pending_bits_q     <= rx_pend_w;
			rx_overflow_pending_bits_q <= rx_overflow_flags & `RX_FIFO_MASK;
			tx_fifo_pending_bits_q     <= tx_pend_w;
			tx_attempt_pending_bits_q  <= tx_attempt_flags;
		end
	end

	// the queue is always a transmitter; other fifos only when selected
	assign tx_capable = fifo_transmit_select | (32'h00000001 << `TXQ_BIT);
	assign wr_req     = reg_wr && (reg_addr == `TX_REQ_IDX);
	assign set_req    = wr_req ? (reg_wdata & tx_capable) : '0;

	// a new request in the same cycle as completion wins: the fifo may already
	// hold a freshly queued message that the completion did not cover
	assign send_req_d = (send_req_q & ~tx_fifo_done) | set_req;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			send_req_q <= `STATUS_RST;
		end else begin
			send_req_q <= send_req_d;
		end
	end

	assign send_request_bits = send_req_q;

	// interrupt code: highest number wins among the pending sources
	assign fifo_any = rx_fifo_pending_bits_q | tx_fifo_pending_bits_q;
	assign code_cls = any_set(tx_attempt_pending_bits_q)  ? cls_tx_att :
	                  any_set(rx_overflow_pending_bits_q) ? cls_rx_ovf :
	                  any_set(fifo_any)                   ? cls_fifo   : cls_none;

	always_comb begin
		unique case (code_cls)
			cls_tx_att: code_d = `CODE_TX_ATT;
			cls_rx_ovf: code_d = `CODE_RX_OVF;
			cls_fifo:   code_d = {2'b00, top_index(fifo_any)};
			cls_none:   code_d = `CODE_NONE;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			code_q <= `CODE_NONE;
		end else begin
			code_q <= code_d;
		end
	end

	assign interrupt_code_vector = code_q;

	// read mux; unmapped indices answer zero
	assign rd_hit  = reg_rd && (reg_addr <= `TX_REQ_IDX);
	assign rdata_d = !rd_hit                      ? '0 :
	                 (reg_addr == `RX_PEND_IDX)   ? rx_fifo_pending_bits_q :
	                 (reg_addr == `RX_OVF_IDX)    ? rx_overflow_pending_bits_q :
	                 (reg_addr == `TX_PEND_IDX)   ? tx_fifo_pending_bits_q :
	                 (reg_addr == `TX_ATT_IDX)    ? tx_attempt_pending_bits_q :
	                 send_req_q;

	// read data is held until the next read strobe
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata_q  <= `STATUS_RST;
			reg_rvalid_q <= 1'b0;
		end else begin
			reg_rvalid_q <= reg_rd;
			if (reg_rd) begin
				reg_rdata_q <= rdata_d;
			end
		end
	end

	// receive status never shows the queue position
	property p_rx_bit0_zero;
		@(posedge clk) disable iff (!resetn)
		(rx_fifo_pending_bits_q[0] == 1'b0) && (rx_overflow_pending_bits_q[0] == 1'b0);
	endproperty
	a_rx_bit0_zero: assert property (p_rx_bit0_zero)
		else $error("receive status bit0 is not zero");

	// a fifo above the queue bit with an enabled receive flag shows pending one cycle later
	property p_rx_pend_follow;
		@(posedge clk) disable iff (!resetn)
		##1 rx_fifo_pending_bits_q == ($past(rx_pend_w));
	endproperty
	a_rx_pend_follow: assert property (p_rx_pend_follow)
		else $error("receive pending does not follow enabled flags");

	// overflow status mirrors the fifo overflow flags above bit0
	property p_rx_ovf_follow;
		@(posedge clk) disable iff (!resetn)
		##1 rx_overflow_pending_bits_q[31:1] == $past(rx_overflow_flags[31:1]);
	endproperty
	a_rx_ovf_follow: assert property (p_rx_ovf_follow)
		else $error("overflow pending does not follow fifo flags");

	// transmit queue pending (bit0) is set the cycle after an enabled queue transmit flag
	property p_tx_pend_follow;
		@(posedge clk) disable iff (!resetn)
		(|(tx_flags[0] & tx_enables[0])) |=> tx_fifo_pending_bits_q[0];
	endproperty
	a_tx_pend_follow: assert property (p_tx_pend_follow)
		else $error("transmit queue pending missing");

	// attempt status mirrors the attempt flags including the queue
	property p_tx_att_follow;
		@(posedge clk) disable iff (!resetn)
		##1 tx_attempt_pending_bits_q == $past(tx_attempt_flags);
	endproperty
	a_tx_att_follow: assert property (p_tx_att_follow)
		else $error("attempt pending does not follow fifo flags");

	// a request write to the queue bit is seen by the engine next cycle
	property p_txq_set;
		@(posedge clk) disable iff (!resetn)
		(wr_req && reg_wdata[0]) |=> send_request_bits[0];
	endproperty
	a_txq_set: assert property (p_txq_set)
		else $error("queue send request not set after write");

	// a request bit may drop only on a completion for that fifo
	property p_clear_on_done;
		@(posedge clk) disable iff (!resetn)
		##1 ($past(send_req_q) & ~send_req_q & ~$past(tx_fifo_done)) == '0;
	endproperty
	a_clear_on_done: assert property (p_clear_on_done)
		else $error("send request cleared without completion");

	// a receive fifo with no request ignores a set attempt
	property p_rx_fifo_ignored;
		@(posedge clk) disable iff (!resetn)
		(wr_req && reg_wdata[1] && !fifo_transmit_select[1] && !send_req_q[1])
			|=> !send_request_bits[1];
	endproperty
	a_rx_fifo_ignored: assert property (p_rx_fifo_ignored)
		else $error("receive fifo accepted a send request");

	// overflow pending without attempt pending reports the overflow code one cycle on
	property p_code_rx_ovf;
		@(posedge clk) disable iff (!resetn)
		(any_set(rx_overflow_pending_bits_q) && !any_set(tx_attempt_pending_bits_q))
			|=> (interrupt_code_vector == `CODE_RX_OVF);
	endproperty
	a_code_rx_ovf: assert property (p_code_rx_ovf)
		else $error("overflow code not reported");

	// attempt pending takes the code over everything else
	property p_code_tx_att;
		@(posedge clk) disable iff (!resetn)
		any_set(tx_attempt_pending_bits_q) |=> (interrupt_code_vector == `CODE_TX_ATT);
	endproperty
	a_code_tx_att: assert property (p_code_tx_att)
		else $error("attempt code not reported");

	// writes elsewhere never touch the request bits
	property p_ro_write_ignored;
		@(posedge clk) disable iff (!resetn)
		(reg_wr && reg_addr != `TX_REQ_IDX && tx_fifo_done == '0)
			|=> $stable(send_request_bits);
	endproperty
	a_ro_write_ignored: assert property (p_ro_write_ignored)
		else $error("write to status vector changed state");

	// an accepted request bit on a transmit-capable fifo is up the next cycle
	property p_req_set;
		@(posedge clk) disable iff (!resetn)
		(reg_wr && reg_addr == `TX_REQ_IDX)
			|=> ((send_request_bits & $past(reg_wdata) & ($past(fifo_transmit_select) | 32'h1))
				== ($past(reg_wdata) & ($past(fifo_transmit_select) | 32'h1)));
	endproperty
	a_req_set: assert property (p_req_set)
		else $error("accepted send request not set");

	// a completion with no new write drops the finished request bits
	property p_req_clear;
		@(posedge clk) disable iff (!resetn)
		(!reg_wr && any_set(send_req_q & tx_fifo_done))
			|=> ((send_request_bits & $past(tx_fifo_done)) == '0);
	endproperty
	a_req_clear: assert property (p_req_clear)
		else $error("send request kept after completion");

	// a read of the attempt vector returns its value at the read strobe
	property p_read_attempt;
		@(posedge clk) disable iff (!resetn)
		(reg_rd && reg_addr == `TX_ATT_IDX)
			|=> (reg_rdata_q == $past(tx_attempt_pending_bits_q));
	endproperty
	a_read_attempt: assert property (p_read_attempt)
		else $error("attempt vector read back wrong");

	// with nothing pending the code reads as no interrupt
	property p_code_none;
		@(posedge clk) disable iff (!resetn)
		!any_set(fifo_any | rx_overflow_pending_bits_q | tx_attempt_pending_bits_q)
			|=> (interrupt_code_vector == `CODE_NONE);
	endproperty
	a_code_none: assert property (p_code_none)
		else $error("idle code not reported");

endmodule : fifo_irq_status

`default_nettype wire

// ==== rtl/fifo_irq_map.svh ====
`ifndef FIFO_IRQ_MAP_SVH
`define FIFO_IRQ_MAP_SVH

// register indices on the controller's register port
`define RX_PEND_IDX   3'h0
`define RX_OVF_IDX    3'h1
`define TX_PEND_IDX   3'h2
`define TX_ATT_IDX    3'h3
`define TX_REQ_IDX    3'h4

// reset value shared by all five registers
`define STATUS_RST    32'h00000000

// receive vectors have no bit for the transmit queue
`define RX_FIFO_MASK  32'hFFFFFFFE

// position of the transmit queue in the transmit vectors
`define TXQ_BIT       0

// interrupt codes reported for the summary vectors
`define CODE_NONE     7'h40
`define CODE_RX_OVF   7'h43
`define CODE_TX_ATT   7'h4A

`endif

// ==== rtl/fifo_irq_pkg.sv ====
`default_nettype none

package fifo_irq_pkg;

	typedef logic [31:0]      word_t;
	typedef logic [2:0]       flag3_t;
	typedef flag3_t [31:0]    flag_arr_t;

	// which source currently owns the interrupt code
	typedef enum logic [1:0] {
		cls_none,
		cls_fifo,
		cls_rx_ovf,
		cls_tx_att
	} code_cls_e;

endpackage : fifo_irq_pkg

`default_nettype wire

// ==== rtl/fifo_flag_reduce.sv ====
`default_nettype none

module fifo_flag_reduce
	import fifo_irq_pkg::*;
(
	input  wire flag_arr_t flags,
	input  wire flag_arr_t enables,
	input  wire word_t     keep_mask,
	output var  word_t     pending
);

	// each fifo reports the or of its enabled condition flags; no memory, so the
	// bit drops on its own as soon as the fifo condition goes away
	always_comb begin
		pending = '0;
		for (int i = 0; i < 32; i++) begin
			pending[i] = |(flags[i] & enables[i]);
		end
		pending = pending & keep_mask;
	end

endmodule : fifo_flag_reduce

`default_nettype wire

// ==== tb/engine_model.sv ====
`default_nettype none

module engine_model
	import fifo_irq_pkg::*;
(
	input  wire logic  clk,
	input  wire logic  resetn,
	input  wire logic  run,
	input  wire word_t send_request_bits,
	output var  word_t tx_fifo_done
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [2:0] cnt_q;
	logic       slow_q;

	// one fifo finishes at a time, lowest first; waits alternate short and long
	// a pulse is never repeated back to back, since the request clears a cycle late
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= 3'h0;
			slow_q <= 1'b0;
			tx_fifo_done <= 32'h00000000;
		end else if (tx_fifo_done != 32'h0 || !run || send_request_bits == 32'h0) begin
			tx_fifo_done <= 32'h00000000;
			cnt_q <= 3'h0;
		end else if (cnt_q == (slow_q ? 3'h6 : 3'h1)) begin
			tx_fifo_done <= send_request_bits & (~send_request_bits + 32'h1);
			cnt_q <= 3'h0;
			slow_q <= ~slow_q;
		end else begin
			cnt_q <= cnt_q + 3'h1;
		end
	end
endmodule : engine_model

`default_nettype wire

// ==== tb/fifo_irq_status_and_tx_request_bench.sv ====
`include "fifo_irq_map.svh"

`default_nettype none

module fifo_irq_status_and_tx_request_bench
	import fifo_irq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic       clk = 1'b0;
	logic       resetn = 1'b0;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [2:0] reg_addr = 3'h0;
	word_t      reg_wdata = 32'h0;
	word_t      rdata;
	logic       rvalid;
	flag_arr_t  rxf = '0;
	flag_arr_t  rxe = '0;
	flag_arr_t  txf = '0;
	flag_arr_t  txe = '0;
	word_t      ovf = 32'h0;
	word_t      att = 32'h0;
	word_t      sel = 32'h0;
	word_t      done;
	word_t      req;
	logic [6:0] code;
	logic       run = 1'b0;
	word_t      rnd_q = 32'h4D;
	word_t      v;
	word_t      w;
	int         n;
	int         cycles = 0;
	int         mismatches = 0;
	int         samples_checked = 0;

	fifo_irq_status DUT (.clk(clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(rdata),
		.reg_rvalid_q(rvalid), .rx_flags(rxf), .rx_enables(rxe), .tx_flags(txf),
		.tx_enables(txe), .rx_overflow_flags(ovf), .tx_attempt_flags(att),
		.fifo_transmit_select(sel), .tx_fifo_done(done), .send_request_bits(req),
		.interrupt_code_vector(code));

	engine_model engine (.clk(clk), .resetn(resetn), .run(run),
		.send_request_bits(req), .tx_fifo_done(done));

	always #50 clk = ~clk;

	// hang guard: the whole run needs well under two thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			give_verdict();
		end
	end

	function automatic word_t next_rnd();
		rnd_q = rnd_q ^ (rnd_q << 13);
		rnd_q = rnd_q ^ (rnd_q >> 17);
		rnd_q = rnd_q ^ (rnd_q << 5);
		return rnd_q;
	endfunction : next_rnd

	function automatic word_t exp_or(flag_arr_t f, flag_arr_t e, word_t m);
		word_t r;
		for (int i = 0; i < 32; i++) r[i] = |(f[i] & e[i]);
		return r & m;
	endfunction : exp_or

	// attempt outranks overflow, which outranks the highest pending fifo
	function automatic logic [6:0] exp_code(word_t rp, word_t tp, word_t ov, word_t at);
		logic [6:0] c;
		c = 7'h40;
		for (int i = 0; i < 32; i++) if (rp[i] | tp[i]) c = 7'(i);
		if (ov != 32'h0) c = 7'h43;
		if (at != 32'h0) c = 7'h4A;
		return c;
	endfunction : exp_code

	task automatic check(input word_t seen, input word_t want);
		samples_checked++;
		if (seen !== want) begin
			mismatches++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, want);
		end
	endtask : check

	task automatic rd(input logic [2:0] a, output word_t d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 check({31'h0, rvalid}, 32'h1);
		d = rdata;
	endtask : rd

	task automatic wr(input logic [2:0] a, input word_t d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic give_verdict();
		$display("comparisons %0d, wrong %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : give_verdict

	initial begin
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		// all vectors empty after reset; index 5 is unmapped and reads zero
		for (int a = 0; a < 6; a++) begin
			rd(3'(a), v);
			check(v, `STATUS_RST);
		end
		check({25'h0, code}, {25'h0, `CODE_NONE});
		$display("test reset values done");
		// random flags; k==1 leaves only the queue overflow bit, which must not count
		for (int k = 0; k < 16; k++) begin
			@(posedge clk);
			w = (k == 1) ? 32'h0 : 32'hFFFFFFFF;
			rxf <= {next_rnd(), next_rnd(), next_rnd()} & {3{w}};
			rxe <= {next_rnd(), next_rnd(), next_rnd()};
			txf <= {next_rnd(), next_rnd(), next_rnd()} & {3{w}};
			txe <= {next_rnd(), next_rnd(), next_rnd()};
			ovf <= (k == 1) ? 32'h1 : (k % 3 == 0) ? next_rnd() : 32'h0;
			att <= (k % 4 == 0) ? next_rnd() : 32'h0;
			wr(3'(k % 4), next_rnd());
			rd(`RX_PEND_IDX, v);
			check(v, exp_or(rxf, rxe, `RX_FIFO_MASK));
			rd(`RX_OVF_IDX, v);
			check(v, ovf & `RX_FIFO_MASK);
			rd(`TX_PEND_IDX, v);
			check(v, exp_or(txf, txe, 32'hFFFFFFFF));
			rd(`TX_ATT_IDX, v);
			check(v, att);
			w = exp_code(exp_or(rxf, rxe, `RX_FIFO_MASK), exp_or(txf, txe, 32'hFFFFFFFF),
				ovf & `RX_FIFO_MASK, att);
			check({25'h0, code}, w);
		end
		$display("test status vectors done");
		// requests held while the engine is stalled, then drained by it
		for (int k = 0; k < 6; k++) begin
			@(posedge clk);
			run <= 1'b0;
			sel <= (k == 0) ? 32'h0 : next_rnd();
			w = next_rnd();
			wr(`TX_REQ_IDX, w);
			rd(`TX_REQ_IDX, v);
			check(v, w & (sel | 32'h1));
			wr(`TX_REQ_IDX, 32'h0);
			rd(`TX_REQ_IDX, v);
			check(v, w & (sel | 32'h1));
			@(posedge clk);
			run <= 1'b1;
			n = 0;
			while (req !== 32'h0 && n < 600) begin
				@(posedge clk);
				#1 n++;
			end
			check(req, 32'h0);
		end
		$display("test send requests done");
		give_verdict();
	end
endmodule : fifo_irq_status_and_tx_request_bench

`default_nettype wire
